// ### verilog/fws_pkg.sv
package fws_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// control bits (write one to act; CTRL_SKIP_WIN holds the value last written to it)
	localparam int CTRL_START_POLL = 0;
	localparam int CTRL_START_ERASE = 1;
	localparam int CTRL_ABORT = 2;
	localparam int CTRL_SKIP_WIN = 3;
	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_OK = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_REJECT = 3;
	localparam int ST_RDY = 4;
	localparam int ST_SKIP = 5;
	localparam int ST_LAST_LSB = 8;
	localparam int ST_DATA_LSB = 16;
	// interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_REJECT = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	localparam logic [31:0] ADDR_RST = 32'h0;
	// status byte bit positions in the flash
	localparam int BIT_DATA_POLL = 7;
	localparam int BIT_T1 = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_WIN = 3;
	localparam int BIT_T2 = 2;
	// flash command bytes
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
	// timing
	localparam int CLK_NS = 10;
	localparam int T_RD_NS = 70;
	localparam int T_WP_NS = 40;
	localparam int T_GAP_NS = 30;
	localparam int T_WIN_US = 50;
	localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WIN_CYC = (T_WIN_US * 1000) / CLK_NS;

	typedef enum {C_IDLE, C_RD, C_WR, C_GAP} fws_cyc_t;
	typedef enum {S_IDLE, S_RD1, S_RD2, S_RECHK, S_ARRAY, S_RESET_CMD, S_WIN_PRE,
		S_ERASE_CMD, S_WIN_POST} fws_state_t;
endpackage

// ### verilog/fws_cycle.sv
`timescale 1ns/1ns
`default_nettype none
module fws_cycle import fws_pkg::*; #(
	parameter int ADDR_W = 20,
	parameter int RD_N = RD_CYC,
	parameter int WP_N = WP_CYC,
	parameter int GAP_N = GAP_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_dq,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic [ADDR_W-1:0] o_addr,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic [7:0] o_dq,
	output logic o_dq_oe
);
	fws_cyc_t state_reg;
	logic [7:0] cnt_reg;
	logic [7:0] dq_s1_reg;
	logic [7:0] dq_s2_reg;
	logic [7:0] dq_s3_reg;
	wire dq_stable = (dq_s2_reg == dq_s3_reg);

	assign o_ready = (state_reg == C_IDLE);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_reg <= C_IDLE;
			cnt_reg <= 8'h00;
			dq_s1_reg <= 8'h00;
			dq_s2_reg <= 8'h00;
			dq_s3_reg <= 8'h00;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_addr <= '0;
			o_ce_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
		end else begin
			dq_s1_reg <= i_dq;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
			o_done <= 1'b0;
			case (state_reg)
				C_IDLE: if (i_req) begin
					o_addr <= i_addr;
					o_ce_n <= 1'b0;
					if (i_wr) begin
						o_we_n <= 1'b0;
						o_dq <= i_wdata;
						o_dq_oe <= 1'b1;
						cnt_reg <= 8'(WP_N - 1);
						state_reg <= C_WR;
					end else begin
						o_oe_n <= 1'b0;
						// access time plus synchroniser depth
						cnt_reg <= 8'(RD_N + 1);
						state_reg <= C_RD;
					end
				end
				C_RD: if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else if (dq_stable) begin
					o_rdata <= dq_s3_reg;
					o_done <= 1'b1;
					o_ce_n <= 1'b1;
					o_oe_n <= 1'b1;
					cnt_reg <= 8'(GAP_N - 1);
					state_reg <= C_GAP;
				end
				C_WR: if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else begin
					o_we_n <= 1'b1;
					o_ce_n <= 1'b1;
					o_done <= 1'b1;
					cnt_reg <= 8'(GAP_N - 1);
					state_reg <= C_GAP;
				end
				C_GAP: if (cnt_reg != 8'h00) begin
					cnt_reg <= cnt_reg - 8'h01;
				end else begin
					// data held through the gap for hold time
					o_dq_oe <= 1'b0;
					state_reg <= C_IDLE;
				end
				default: state_reg <= C_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### verilog/fws_ctrl.sv
// Summary of operation
// - start toggle check with two back-to-back full byte reads, compare toggle bit
// - equal toggle bits mean done; next read returns valid array data
// - toggling with failure bit high: recheck toggling once more
// - still toggling on recheck means failure; issue reset command
// - may keep polling or leave; restart always from first double read
// - after any failure the host sends the reset command
// - window check skipped only while command spacing stays under 50 us
// - check window bit before and after each further sector erase command
// - status reads use the program address or a sector chosen for erase
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fws_ctrl import fws_pkg::*; #(
	parameter int ADDR_W = 20,
	parameter int WIN_N = WIN_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic o_flash_ce_n,
	output logic o_flash_oe_n,
	output logic o_flash_we_n,
	output logic [7:0] o_flash_dq,
	output logic o_flash_dq_oe,
	input wire logic [7:0] i_flash_dq,
	input wire logic i_ready_busy_n,
	output logic o_irq
);
	fws_state_t state_reg;
	logic [31:0] addr_reg;
	logic [IRQ_W-1:0] stat_reg;
	logic [IRQ_W-1:0] mask_reg;
	logic [IRQ_W-1:0] stat_next;
	logic [IRQ_W-1:0] ev;
	logic [7:0] first_reg;
	logic [7:0] last_reg;
	logic [7:0] data_reg;
	logic ok_reg;
	logic fail_reg;
	logic reject_reg;
	logic skip_reg;
	logic abort_reg;
	logic sent_reg;
	logic [15:0] space_reg;
	logic rb_s1_reg;
	logic rb_s2_reg;
	logic rb_s3_reg;
	logic rb_reg;
	logic cyc_ready;
	logic cyc_done;
	logic [7:0] cyc_rdata;

	// bus decode
	wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire wb_wr = wb_req & i_wb_we;
	wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	wire [31:0] wdat = i_wb_dat & wmask;
	wire wr_ctrl = wb_wr & (i_wb_adr == OFS_CTRL);
	wire wr_addr = wb_wr & (i_wb_adr == OFS_ADDR);
	wire wr_istat = wb_wr & (i_wb_adr == OFS_IRQ_STAT);
	wire wr_mask = wb_wr & (i_wb_adr == OFS_IRQ_MASK);
	wire start_poll = wr_ctrl & wdat[CTRL_START_POLL];
	wire start_erase = wr_ctrl & wdat[CTRL_START_ERASE];
	wire abort_req = wr_ctrl & wdat[CTRL_ABORT];
	wire idle = (state_reg == S_IDLE);
	wire [31:0] status_word = {8'h00, data_reg, last_reg, 2'b00, skip_reg, rb_reg, reject_reg,
		fail_reg, ok_reg, ~idle};
	wire [31:0] rd_mux = (i_wb_adr == OFS_CTRL) ? {28'h0, skip_reg, 3'b000} :
		(i_wb_adr == OFS_ADDR) ? addr_reg :
		(i_wb_adr == OFS_STATUS) ? status_word :
		(i_wb_adr == OFS_IRQ_STAT) ? {29'h0, stat_reg} :
		(i_wb_adr == OFS_IRQ_MASK) ? {29'h0, mask_reg} : 32'h0;

	// flash cycle selection
	wire st_write = (state_reg == S_RESET_CMD) | (state_reg == S_ERASE_CMD);
	wire st_read = (state_reg == S_RD1) | (state_reg == S_RD2) | (state_reg == S_RECHK) |
		(state_reg == S_ARRAY) | (state_reg == S_WIN_PRE) | (state_reg == S_WIN_POST);
	wire cyc_req = (st_write | st_read) & ~sent_reg & cyc_ready;
	wire [7:0] cyc_wdata = (state_reg == S_RESET_CMD) ? CMD_RESET : CMD_SECT_ERASE;
	wire [ADDR_W-1:0] cyc_addr = addr_reg[ADDR_W-1:0];
	wire toggling = first_reg[BIT_T1] ^ cyc_rdata[BIT_T1];
	wire win_open = skip_reg & (space_reg < 16'(WIN_N));
	wire rb_agree = (rb_s2_reg == rb_s3_reg);

	assign stat_next = (stat_reg & ~(wr_istat ? wdat[IRQ_W-1:0] : '0)) | ev;
	assign o_irq = |(stat_reg & mask_reg);

	fws_cycle #(
		.ADDR_W(ADDR_W)
	) u_cycle (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_req(cyc_req),
		.i_wr(st_write),
		.i_addr(cyc_addr),
		.i_wdata(cyc_wdata),
		.i_dq(i_flash_dq),
		.o_ready(cyc_ready),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_addr(o_flash_addr),
		.o_ce_n(o_flash_ce_n),
		.o_oe_n(o_flash_oe_n),
		.o_we_n(o_flash_we_n),
		.o_dq(o_flash_dq),
		.o_dq_oe(o_flash_dq_oe)
	);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
			addr_reg <= ADDR_RST;
			mask_reg <= IRQ_RST;
			stat_reg <= IRQ_RST;
			skip_reg <= 1'b0;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= wb_req ? rd_mux : 32'h0;
			stat_reg <= stat_next;
			if (wr_addr)
				addr_reg <= (addr_reg & ~wmask) | wdat;
			if (wr_mask)
				mask_reg <= wdat[IRQ_W-1:0];
			if (wr_ctrl)
				skip_reg <= wdat[CTRL_SKIP_WIN];
		end
	end

	// ready/busy pin synchroniser
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rb_s1_reg <= 1'b1;
			rb_s2_reg <= 1'b1;
			rb_s3_reg <= 1'b1;
			rb_reg <= 1'b1;
		end else begin
			rb_s1_reg <= i_ready_busy_n;
			rb_s2_reg <= rb_s1_reg;
			rb_s3_reg <= rb_s2_reg;
			if (rb_agree)
				rb_reg <= rb_s3_reg;
		end
	end

	// spacing since last sector erase command
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			space_reg <= 16'hffff;
		else if (state_reg == S_ERASE_CMD && cyc_done)
			space_reg <= 16'h0000;
		else if (space_reg != 16'hffff)
			space_reg <= space_reg + 16'h0001;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			sent_reg <= 1'b0;
		else if (cyc_done)
			sent_reg <= 1'b0;
		else if (cyc_req)
			sent_reg <= 1'b1;
	end

	always_comb begin
		ev = '0;
		if (cyc_done) begin
			case (state_reg)
				S_ARRAY: ev[IRQ_DONE] = 1'b1;
				S_RESET_CMD: ev[IRQ_FAIL] = 1'b1;
				S_WIN_PRE: ev[IRQ_REJECT] = cyc_rdata[BIT_WIN];
				S_ERASE_CMD: ev[IRQ_DONE] = win_open;
				S_WIN_POST: begin
					ev[IRQ_REJECT] = cyc_rdata[BIT_WIN];
					ev[IRQ_DONE] = ~cyc_rdata[BIT_WIN];
				end
				default: ev = '0;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_reg <= S_IDLE;
			first_reg <= 8'h00;
			last_reg <= 8'h00;
			data_reg <= 8'h00;
			ok_reg <= 1'b0;
			fail_reg <= 1'b0;
			reject_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			if (abort_req && !idle)
				abort_reg <= 1'b1;
			case (state_reg)
				S_IDLE: begin
					abort_reg <= 1'b0;
					if (start_poll) begin
						state_reg <= S_RD1;
						ok_reg <= 1'b0;
						fail_reg <= 1'b0;
					end else if (start_erase) begin
						ok_reg <= 1'b0;
						reject_reg <= 1'b0;
						state_reg <= win_open ? S_ERASE_CMD : S_WIN_PRE;
					end
				end
				S_RD1: if (cyc_done) begin
					first_reg <= cyc_rdata;
					last_reg <= cyc_rdata;
					state_reg <= S_RD2;
				end
				S_RD2: if (cyc_done) begin
					last_reg <= cyc_rdata;
					first_reg <= cyc_rdata;
					if (!toggling)
						state_reg <= S_ARRAY;
					else if (cyc_rdata[BIT_TIMEOUT])
						state_reg <= S_RECHK;
					else if (abort_reg)
						state_reg <= S_IDLE;
				end
				S_RECHK: if (cyc_done) begin
					last_reg <= cyc_rdata;
					state_reg <= toggling ? S_RESET_CMD : S_ARRAY;
				end
				S_ARRAY: if (cyc_done) begin
					data_reg <= cyc_rdata;
					ok_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				S_RESET_CMD: if (cyc_done) begin
					fail_reg <= 1'b1;
					state_reg <= S_IDLE;
				end
				S_WIN_PRE: if (cyc_done) begin
					last_reg <= cyc_rdata;
					if (cyc_rdata[BIT_WIN]) begin
						reject_reg <= 1'b1;
						state_reg <= S_IDLE;
					end else begin
						state_reg <= S_ERASE_CMD;
					end
				end
				S_ERASE_CMD: if (cyc_done) begin
					ok_reg <= win_open;
					state_reg <= win_open ? S_IDLE : S_WIN_POST;
				end
				S_WIN_POST: if (cyc_done) begin
					last_reg <= cyc_rdata;
					reject_reg <= cyc_rdata[BIT_WIN];
					ok_reg <= ~cyc_rdata[BIT_WIN];
					state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	property p_two_reads;
		@(posedge i_sys_clk) disable iff (i_rst)
		(state_reg == S_RD1 && cyc_done) |=> (state_reg == S_RD2) && !ok_reg;
	endproperty
	a_two_reads: assert property (p_two_reads) else $error("first read not followed by second");

	property p_stable_done;
		@(posedge i_sys_clk) disable iff (i_rst)
		(state_reg == S_RD2 && cyc_done && !toggling) |=> (state_reg == S_ARRAY) ##[1:60]
			(state_reg == S_IDLE && ok_reg);
	endproperty
	a_stable_done: assert property (p_stable_done) else $error("stable toggle did not end in array read");

	property p_recheck;
		@(posedge i_sys_clk) disable iff (i_rst)
		(state_reg == S_RD2 && cyc_done && toggling && cyc_rdata[BIT_TIMEOUT]) |=>
			(state_reg == S_RECHK);
	endproperty
	a_recheck: assert property (p_recheck) else $error("failure bit without recheck");

	property p_fail_reset;
		@(posedge i_sys_clk) disable iff (i_rst)
		(state_reg == S_RECHK && cyc_done && toggling) |=> (state_reg == S_RESET_CMD) ##[1:60]
			(fail_reg && stat_reg[IRQ_FAIL]);
	endproperty
	a_fail_reset: assert property (p_fail_reset) else $error("failed recheck did not reset device");

	property p_reset_cmd;
		@(posedge i_sys_clk) disable iff (i_rst)
		(cyc_req && state_reg == S_RESET_CMD) |-> st_write && (cyc_wdata == CMD_RESET);
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset command byte wrong");

	property p_restart;
		@(posedge i_sys_clk) disable iff (i_rst)
		(idle && start_poll) |=> (state_reg == S_RD1) && !sent_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("poll did not restart from first read");

	property p_window_pre;
		@(posedge i_sys_clk) disable iff (i_rst)
		(idle && !start_poll && start_erase && !win_open) |=> (state_reg == S_WIN_PRE);
	endproperty
	a_window_pre: assert property (p_window_pre) else $error("window check skipped");

	property p_window_closed;
		@(posedge i_sys_clk) disable iff (i_rst)
		(state_reg == S_WIN_PRE && cyc_done && cyc_rdata[BIT_WIN]) |=> idle && reject_reg &&
			stat_reg[IRQ_REJECT];
	endproperty
	a_window_closed: assert property (p_window_closed) else $error("closed window not reported");

	property p_status_addr;
		@(posedge i_sys_clk) disable iff (i_rst)
		(cyc_req && st_read) |-> (cyc_addr == addr_reg[ADDR_W-1:0]);
	endproperty
	a_status_addr: assert property (p_status_addr) else $error("status read at wrong address");

	property p_toggle_cmp;
		@(posedge i_sys_clk) disable iff (i_rst)
		(state_reg == S_RD2 && cyc_done && toggling && !cyc_rdata[BIT_TIMEOUT] && !abort_reg) |=>
			(state_reg == S_RD2) && (first_reg == $past(cyc_rdata));
	endproperty
	a_toggle_cmp: assert property (p_toggle_cmp) else $error("toggling read not chained");
endmodule
`default_nettype wire

// ### testbench/fws_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fws_flash_model #(
	parameter int WIN_N = 200
) (
	input wire logic i_clk,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic [19:0] i_addr,
	input wire logic [7:0] i_dq,
	output logic [7:0] o_dq,
	output logic o_dq_en,
	output logic o_ready_busy_n,
	input wire logic i_load,
	input wire logic i_erase,
	input var int i_left,
	input var int i_fail_rd,
	input wire logic [7:0] i_data,
	output logic [19:0] o_rd_addr,
	output int o_rd_cnt,
	output int o_rst_cnt,
	output int o_sect_cnt
);
	logic busy = 1'b0;
	logic frz = 1'b0;
	logic t1 = 1'b0;
	logic t2 = 1'b0;
	logic tmo = 1'b0;
	logic rd_on = 1'b0;
	logic [7:0] cmd = 8'h00;
	int win = 0;
	assign o_dq_en = ~i_ce_n & ~i_oe_n;
	initial begin
		o_ready_busy_n = 1'b1;
		o_dq = 8'h00;
		o_rd_addr = 20'h00000;
	end
	always @(posedge i_clk) begin
		if (i_load) begin
			busy = 1'b1;
			frz = 1'b0;
			tmo = 1'b0;
			win = 0;
			o_rd_cnt = 0;
			o_rst_cnt = 0;
			o_sect_cnt = 0;
		end else if (win < WIN_N) begin
			win++;
		end
		if (!i_ce_n && !i_we_n) cmd = i_dq;
		if (i_we_n && cmd == 8'hf0) begin
			busy = 1'b0;
			tmo = 1'b0;
			o_rst_cnt++;
		end
		// extra sector only while the window is open
		if (i_we_n && cmd == 8'h30 && busy && i_erase && win < WIN_N) begin
			win = 0;
			o_sect_cnt++;
		end
		if (i_we_n) cmd = 8'h00;
		if (!i_ce_n && !i_oe_n && !rd_on) begin
			o_rd_cnt++;
			o_rd_addr <= i_addr;
			if (busy) begin
				if (i_fail_rd > 0 && o_rd_cnt >= i_fail_rd) tmo = 1'b1;
				t1 = ~t1;
				t2 = t2 ^ i_erase;
				o_dq <= {~i_erase & ~i_data[7], t1, tmo, 1'b0, i_erase && win >= WIN_N, t2, 2'b00};
				busy = o_rd_cnt < i_left;
				frz = !busy;
			end else if (frz) begin
				frz = 1'b0;
			end else begin
				o_dq <= i_data;
			end
		end
		rd_on = !i_ce_n && !i_oe_n;
		o_ready_busy_n <= ~busy;
	end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench import fws_pkg::*;;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] rdat, q;
	logic ack, ce_n, oe_n, we_n, dq_oe, irq, m_en, rb_n;
	logic [19:0] faddr, m_addr, fa;
	logic [7:0] dq_out, m_dq;
	logic [7:0] data = 8'h00;
	wire logic [7:0] dq_bus;
	logic load = 1'b0;
	logic erase = 1'b0;
	int left = 0, fail_rd = 0, rd_cnt, rst_cnt, sect_cnt, n_errors = 0, compares = 0, i;
	logic [7:0] offs[$] = '{OFS_ADDR, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h20};
	always #5 i_sys_clk = ~i_sys_clk;
	// released bus shows the inverse of the model's last output value
	assign dq_bus = dq_oe ? dq_out : (m_en ? m_dq : ~m_dq);
	fws_ctrl #(.ADDR_W(20), .WIN_N(200)) DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.o_wb_dat(rdat), .o_wb_ack(ack), .o_flash_addr(faddr), .o_flash_ce_n(ce_n),
		.o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_dq(dq_out), .o_flash_dq_oe(dq_oe),
		.i_flash_dq(dq_bus), .i_ready_busy_n(rb_n), .o_irq(irq));
	fws_flash_model #(.WIN_N(200)) mdl (.i_clk(i_sys_clk), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_addr(faddr), .i_dq(dq_bus), .o_dq(m_dq), .o_dq_en(m_en),
		.o_ready_busy_n(rb_n), .i_load(load), .i_erase(erase), .i_left(left), .i_fail_rd(fail_rd),
		.i_data(data), .o_rd_addr(m_addr), .o_rd_cnt(rd_cnt), .o_rst_cnt(rst_cnt),
		.o_sect_cnt(sect_cnt));
	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		compares++;
		if ((got & m) !== (exp & m)) begin
			n_errors++;
			$display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk_reg(32'(ack), 32'h1, 32'h1);
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge i_sys_clk);
			n++;
		end
		chk_reg(32'(irq), 32'h1, 32'h1);
	endtask
	task automatic arm(input int l, input int f, input logic e);
		@(posedge i_sys_clk);
		left <= l;
		fail_rd <= f;
		erase <= e;
		data <= 8'($urandom);
		load <= 1'b1;
		@(posedge i_sys_clk);
		load <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
	endtask
	function automatic logic [31:0] st(input logic ok, input logic [7:0] d);
		logic [31:0] v;
		v = 32'h0;
		v[ST_OK] = ok;
		v[ST_FAIL] = ~ok;
		v[ST_DATA_LSB +: 8] = d;
		return v;
	endfunction
	task automatic poll(input int l, input int f, input logic ok);
		arm(l, f, 1'b0);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_START_POLL);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk_reg(q, 32'h1 << ST_BUSY, (32'h1 << ST_BUSY) | (32'h1 << ST_RDY));
		wait_irq();
		wb(1'b0, OFS_STATUS, 32'h0);
		chk_reg(q, st(ok, data), ok ? 32'h00ff_00ef : 32'hef);
		chk_cnt(rd_cnt, ok ? l + 2 : f + 1);
		chk_cnt(rst_cnt, ok ? 0 : 1);
		chk_reg(32'(m_addr), 32'(fa), 32'hfffff);
		wb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk_reg(q, ok ? 32'h1 : 32'h2, 32'h7);
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		chk_reg(32'(irq), 32'h0, 32'h1);
		$display("poll test ok=%0d done", ok);
	endtask
	initial begin
		#600000;
		n_errors++;
		$display("CHECK FAILED at %0t: timeout", $time);
		print_verdict();
	end
	initial begin
		void'($urandom(32'ha374d63d));
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk_reg(q, 32'h1 << ST_RDY, 32'hffffffff);
		foreach (offs[k]) begin
			wb(1'b0, offs[k], 32'h0);
			chk_reg(q, 32'h0, 32'hffffffff);
		end
		fa = 20'($urandom);
		wb(1'b1, OFS_ADDR, 32'(fa));
		wb(1'b0, OFS_ADDR, 32'h0);
		chk_reg(q, 32'(fa), 32'hffffffff);
		wb(1'b1, OFS_IRQ_MASK, 32'h7);
		$display("reset test done");
		poll(1 + $urandom % 6, 0, 1'b1);
		i = 2 + $urandom % 5;
		poll(i, i, 1'b1);
		poll(1000000, i, 1'b0);
		arm(1000000, 0, 1'b0);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_START_POLL);
		repeat (60) @(posedge i_sys_clk);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_ABORT);
		i = 0;
		do begin
			wb(1'b0, OFS_STATUS, 32'h0);
			i++;
		end while (q[ST_BUSY] !== 1'b0 && i < 100);
		chk_reg(q, 32'h0, 32'h1 << ST_BUSY);
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		poll(3, 0, 1'b1);
		$display("abort test done");
		arm(1000000, 0, 1'b1);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_START_ERASE);
		wait_irq();
		wb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk_reg(q, 32'h1 << IRQ_DONE, 32'h7);
		chk_cnt(sect_cnt, 1);
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		// let the acceptance window run out
		repeat (250) @(posedge i_sys_clk);
		wb(1'b1, OFS_CTRL, 32'h1 << CTRL_START_ERASE);
		wait_irq();
		wb(1'b0, OFS_STATUS, 32'h0);
		chk_reg(q, 32'h1 << ST_REJECT, 32'h1 << ST_REJECT);
		chk_cnt(sect_cnt, 1);
		wb(1'b1, OFS_IRQ_MASK, 32'h0);
		chk_reg(32'(irq), 32'h0, 32'h1);
		wb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk_reg(q, 32'h1 << IRQ_REJECT, 32'h7);
		wb(1'b1, OFS_IRQ_MASK, 32'h7);
		chk_reg(32'(irq), 32'h1, 32'h1);
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		chk_reg(32'(irq), 32'h0, 32'h1);
		$display("erase test done");
		// skip mode: second command inside the window goes out with no reads
		arm(1000000, 0, 1'b1);
		wb(1'b1, OFS_CTRL, (32'h1 << CTRL_START_ERASE) | (32'h1 << CTRL_SKIP_WIN));
		wait_irq();
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		wb(1'b1, OFS_CTRL, (32'h1 << CTRL_START_ERASE) | (32'h1 << CTRL_SKIP_WIN));
		wait_irq();
		wb(1'b0, OFS_STATUS, 32'h0);
		chk_reg(q, (32'h1 << ST_OK) | (32'h1 << ST_SKIP), 32'h2f);
		chk_cnt(sect_cnt, 2);
		chk_cnt(rd_cnt, 2);
		wb(1'b0, OFS_CTRL, 32'h0);
		chk_reg(q, 32'h1 << CTRL_SKIP_WIN, 32'hffffffff);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_IRQ_STAT, 32'h7);
		chk_reg(32'(irq), 32'h0, 32'h1);
		$display("skip test done");
		print_verdict();
	end
endmodule
`default_nettype wire
